/* pawt_timer.sv */
// Behaviour
// - stall 3+i+j+(2+j)*k clocks total
// - fractional k rounds up to whole
// - i is upper wait-control nibble, 0/1
// - j is lower nibble, addend and divisor
// - control group registers use ratio x1..x2
// - 8-bit message data writes use x4..x5
// - 16-bit message data writes use x2..x3
// - pointer and buffer reads use x3..x4
// - forbidden-clock wait held until reset
// - no next instruction while wait runs
`timescale 1ns/1ns
`default_nettype none
module pawt_timer (
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_b,
    // access from the processor core
    input  wire logic                          i_acc_req,
    input  wire logic                          i_acc_wr,
    input  wire logic                          i_acc_size16,
    input  wire pawt_pkg::pawt_cls_t           i_acc_cls,
    // configuration and clock status
    input  wire logic [7:0]                    i_system_wait_control,
    input  wire logic [pawt_pkg::RATIO_W-1:0]  i_clk_ratio,
    input  wire logic                          i_cpu_on_subclk_main_off,
    input  wire logic                          i_cpu_on_int_osc,
    // answer to the processor core
    output logic                               o_stall_ff,
    output logic                               o_done_ff,
    output logic                               o_locked_ff
);

    // ************************************************************
    // decode
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CALC,
        ST_RUN,
        ST_LOCK
    } pawt_st_t;

    pawt_st_t                      st_ff;
    pawt_st_t                      nxt_st;
    logic [pawt_pkg::MULT_W-1:0]   mult;
    logic                          wait_i;
    logic                          wait_j;
    logic                          wait_i_ff;
    logic                          wait_j_ff;
    logic                          take;
    logic                          forbidden;
    logic [pawt_pkg::K_W-1:0]      k_val;
    logic [pawt_pkg::CNT_W-1:0]    total;
    logic [pawt_pkg::CNT_W-1:0]    cnt_ff;
    logic [pawt_pkg::CNT_W-1:0]    expect_ff;
    logic [pawt_pkg::CNT_W-1:0]    stall_len_ff;

    always_comb begin
        mult      = pawt_pkg::k_mult(i_acc_cls, i_acc_wr, i_acc_size16);
        wait_i    = i_system_wait_control[pawt_pkg::WAIT_UPPER_LSB];
        wait_j    = i_system_wait_control[pawt_pkg::WAIT_LOWER_LSB];
        forbidden = i_cpu_on_subclk_main_off | i_cpu_on_int_osc;
        take      = (st_ff == ST_IDLE) && i_acc_req && (mult != pawt_pkg::MULT_NONE);
    end

    // k is registered inside the helper, which costs the calc cycle
    pawt_kcalc u_kcalc (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_mult  (mult),
        .i_ratio (i_clk_ratio),
        .i_j     (wait_j),
        .o_k_ff  (k_val)
    );

    always_comb begin
        total = pawt_pkg::BASE_CLKS + pawt_pkg::CNT_W'(wait_i_ff) + pawt_pkg::CNT_W'(wait_j_ff)
              + pawt_pkg::CNT_W'((pawt_pkg::CNT_W'(pawt_pkg::DIV_BASE) + pawt_pkg::CNT_W'(wait_j_ff))
              * pawt_pkg::CNT_W'(k_val));
    end

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_IDLE: if (take) begin
                nxt_st = forbidden ? ST_LOCK : ST_CALC;
            end
            ST_CALC: nxt_st = ST_RUN;
            ST_RUN:  if (cnt_ff == '0) begin
                nxt_st = ST_IDLE;
            end
            ST_LOCK: nxt_st = ST_LOCK;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_ff <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // operands latched so a change mid-access cannot shift the count
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wait_i_ff <= 1'b0;
            wait_j_ff <= 1'b0;
        end else if (take) begin
            wait_i_ff <= wait_i;
            wait_j_ff <= wait_j;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_ff    <= '0;
            expect_ff <= '0;
        end else if (st_ff == ST_CALC) begin
            cnt_ff    <= total - pawt_pkg::PIPE_CLKS;
            expect_ff <= total;
        end else if (st_ff == ST_RUN && cnt_ff != '0) begin
            cnt_ff    <= cnt_ff - 16'h0001;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_stall_ff  <= 1'b0;
            o_done_ff   <= 1'b0;
            o_locked_ff <= 1'b0;
        end else begin
            o_stall_ff  <= (nxt_st != ST_IDLE);
            o_done_ff   <= (st_ff == ST_RUN) && (nxt_st == ST_IDLE);
            o_locked_ff <= (nxt_st == ST_LOCK);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            stall_len_ff <= '0;
        end else if (o_stall_ff) begin
            stall_len_ff <= stall_len_ff + 16'h0001;
        end else begin
            stall_len_ff <= '0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_stall_follows_take: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        take |=> o_stall_ff)
        else $error("stall did not start after a qualifying access");

    a_stall_exact_length: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_done_ff && !o_locked_ff) |-> (stall_len_ff == expect_ff))
        else $error("stall length differs from the access cycle count");

    a_lock_never_ends: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_locked_ff |=> (o_locked_ff && o_stall_ff && !o_done_ff))
        else $error("forbidden-clock wait was released without reset");

    a_lock_on_forbidden: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (take && forbidden) |=> o_locked_ff)
        else $error("access on a forbidden clock did not lock");

    a_done_ends_stall: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_done_ff |-> (!o_stall_ff && $past(o_stall_ff)))
        else $error("completion seen while the wait still runs");

    a_i_from_upper: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        take |=> (wait_i_ff == $past(i_system_wait_control[4])))
        else $error("upper wait value not taken from the upper nibble");

    a_j_from_lower: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        take |=> (wait_j_ff == $past(i_system_wait_control[0])))
        else $error("lower wait value not taken from the lower nibble");

    a_ctrl_mult_two: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_acc_cls == pawt_pkg::CLS_CTRL) |-> (mult == 3'h2))
        else $error("control group multiplier wrong");

    a_data_wr_mult: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_acc_cls == pawt_pkg::CLS_MSG_DATA && i_acc_wr) |-> (mult == (i_acc_size16 ? 3'h3 : 3'h5)))
        else $error("message data write multiplier wrong");

    a_read_mult_four: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!i_acc_wr && i_acc_cls inside {pawt_pkg::CLS_HIST_PTR, pawt_pkg::CLS_LOG_PTR,
            pawt_pkg::CLS_MSG_DATA, pawt_pkg::CLS_MSG_OTHER}) |-> (mult == 3'h4))
        else $error("pointer or buffer read multiplier wrong");

    a_stall_until_done: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_stall_ff && !o_locked_ff) |=> (o_stall_ff || o_done_ff))
        else $error("wait dropped without completing the access");

    a_skip_unlisted_access: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (st_ff == ST_IDLE && i_acc_req && mult == pawt_pkg::MULT_NONE) |=> !o_stall_ff)
        else $error("access without extra wait was stalled");

    a_done_one_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_done_ff |=> !o_done_ff)
        else $error("completion pulse longer than one clock");

    a_no_done_locked: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_locked_ff |-> !o_done_ff)
        else $error("completion reported during a forbidden-clock wait");

    a_lock_needs_forbid: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_locked_ff) |-> $past(forbidden))
        else $error("lock entered without a forbidden clock");

endmodule
`default_nettype wire

/* pawt_pkg.sv */
package pawt_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned RATIO_W = 12;        // main/can clock ratio, unsigned 8.4 fixed point
    localparam int unsigned FRAC_W  = 4;
    localparam int unsigned MULT_W  = 3;
    localparam int unsigned NUM_W   = 16;
    localparam int unsigned K_W     = 12;
    localparam int unsigned CNT_W   = 16;

    // ************************************************************
    // access cycle constants
    // ************************************************************
    localparam logic [CNT_W-1:0]   BASE_CLKS  = 16'h0003;
    localparam logic [CNT_W-1:0]   PIPE_CLKS  = 16'h0002;
    localparam logic [NUM_W-1:0]   RATIO_ONE  = 16'h0010;
    localparam logic [NUM_W-1:0]   DIV_BASE   = 16'h0002;
    localparam logic [MULT_W-1:0]  MULT_NONE  = 3'h0;
    localparam logic [MULT_W-1:0]  MULT_X2    = 3'h2;
    localparam logic [MULT_W-1:0]  MULT_X3    = 3'h3;
    localparam logic [MULT_W-1:0]  MULT_X4    = 3'h4;
    localparam logic [MULT_W-1:0]  MULT_X5    = 3'h5;

    // ************************************************************
    // wait control fields
    // ************************************************************
    localparam int unsigned WAIT_UPPER_LSB = 4;
    localparam int unsigned WAIT_LOWER_LSB = 0;

    // ************************************************************
    // register groups behind the bridge
    // ************************************************************
    typedef enum logic [2:0] {
        CLS_NONE,
        CLS_CTRL,
        CLS_HIST_PTR,
        CLS_LOG_PTR,
        CLS_MSG_DATA,
        CLS_MSG_OTHER
    } pawt_cls_t;

    // worst-case ratio multiplier per group and access; zero when no extra wait
    function automatic logic [MULT_W-1:0] k_mult(input pawt_cls_t cls, input logic wr, input logic size16);
        logic [MULT_W-1:0] m;
        m = MULT_NONE;
        unique case (cls)
            CLS_CTRL:      m = MULT_X2;
            CLS_HIST_PTR:  m = wr ? MULT_X2 : MULT_X4;
            CLS_LOG_PTR:   m = wr ? MULT_NONE : MULT_X4;
            CLS_MSG_DATA:  m = wr ? (size16 ? MULT_X3 : MULT_X5) : MULT_X4;
            CLS_MSG_OTHER: m = wr ? MULT_NONE : MULT_X4;
            default:       m = MULT_NONE;
        endcase
        return m;
    endfunction

endpackage

/* pawt_kcalc.sv */
`timescale 1ns/1ns
`default_nettype none
module pawt_kcalc (
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_b,
    // operands
    input  wire logic [pawt_pkg::MULT_W-1:0]   i_mult,
    input  wire logic [pawt_pkg::RATIO_W-1:0]  i_ratio,
    input  wire logic                          i_j,
    // result
    output logic      [pawt_pkg::K_W-1:0]      o_k_ff
);

    logic [pawt_pkg::NUM_W-1:0] num;
    logic [pawt_pkg::NUM_W-1:0] div;
    logic [pawt_pkg::NUM_W-1:0] quo;

    // ratio is fixed point, so the divisor carries the same scale
    always_comb begin
        num = pawt_pkg::NUM_W'(i_mult * i_ratio) + pawt_pkg::RATIO_ONE;
        div = (pawt_pkg::DIV_BASE + pawt_pkg::NUM_W'(i_j)) << pawt_pkg::FRAC_W;
        quo = (num + div - 16'h0001) / div;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_k_ff <= '0;
        end else begin
            o_k_ff <= quo[pawt_pkg::K_W-1:0];
        end
    end

    // the first edge after reset still shows the cleared k, so it is skipped
    a_k_rounds_up: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $past(i_rst_b) |-> ((32'(o_k_ff) * 32'($past(div)) >= 32'($past(num)))
        && (o_k_ff == '0 || 32'(o_k_ff - 12'h001) * 32'($past(div)) < 32'($past(num)))))
        else $error("k is not the rounded-up quotient");

endmodule
`default_nettype wire

/* pawt_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pawt_core_model (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    // command from the bench
    input  wire logic                 i_go,
    input  wire logic                 i_wr,
    input  wire logic                 i_size16,
    input  wire pawt_pkg::pawt_cls_t  i_cls,
    // answer from the timer
    input  wire logic                 i_stall,
    input  wire logic                 i_done,
    // access towards the timer
    output logic                      o_req_ff,
    output logic                      o_wr_ff,
    output logic                      o_size16_ff,
    output pawt_pkg::pawt_cls_t       o_cls_ff,
    // stalled clocks of the last access
    output logic                      o_fin_ff,
    output logic [15:0]               o_cnt_ff
);
    logic        busy_ff;
    logic [15:0] cnt_ff;

    // the core never starts the next access while a wait runs
    // and the bench alone decides when a forbidden clock is in use
    always_ff @(posedge i_clk) begin
        o_fin_ff <= 1'b0;
        o_req_ff <= 1'b0;
        if (!i_rst_b) begin
            busy_ff     <= 1'b0;
            cnt_ff      <= 16'h0000;
            o_cnt_ff    <= 16'h0000;
            o_wr_ff     <= 1'b0;
            o_size16_ff <= 1'b0;
            o_cls_ff    <= pawt_pkg::CLS_NONE;
        end else begin
            // no stall one clock after the request: the access needed no wait
            if (busy_ff && !o_req_ff && (i_done || (!i_stall && cnt_ff == 16'h0000))) begin
                busy_ff  <= 1'b0;
                o_fin_ff <= 1'b1;
                o_cnt_ff <= cnt_ff;
            end else if (busy_ff && i_stall) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
            if (i_go && (!busy_ff || i_done)) begin
                o_req_ff    <= 1'b1;
                busy_ff     <= 1'b1;
                cnt_ff      <= 16'h0000;
                o_wr_ff     <= i_wr;
                o_size16_ff <= i_size16;
                o_cls_ff    <= i_cls;
            end
        end
    end
endmodule
`default_nettype wire

/* peripheral_access_wait_timer_test.sv */
`timescale 1ns/1ns
`default_nettype none
module peripheral_access_wait_timer_test;
    typedef struct packed {
        pawt_pkg::pawt_cls_t cls;
        logic                wr;
        logic                s16;
        logic [11:0]         ratio;
        logic [7:0]          swc;
        logic [2:0]          m;
    } pawt_row_t;

    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic go = 1'b0, wr = 1'b0, s16 = 1'b0, sub_off = 1'b0, int_osc = 1'b0;
    pawt_pkg::pawt_cls_t cls = pawt_pkg::CLS_NONE;
    logic [11:0] ratio = 12'h010;
    logic [7:0] swc = 8'h00;
    logic acc_req, acc_wr, acc_s16, stall, done, locked, fin;
    pawt_pkg::pawt_cls_t acc_cls;
    logic [15:0] cnt;
    int errors = 0;
    int checked = 0;
    // wait control only ever takes one of the three legal settings
    // ratio is 8.4 fixed point; m is the worst-case multiplier of the group
    pawt_row_t rows [12] = '{
        '{pawt_pkg::CLS_CTRL, 1'b0, 1'b0, 12'h010, 8'h00, 3'h2},
        '{pawt_pkg::CLS_CTRL, 1'b1, 1'b0, 12'h018, 8'h01, 3'h2},
        '{pawt_pkg::CLS_HIST_PTR, 1'b1, 1'b0, 12'h020, 8'h11, 3'h2},
        '{pawt_pkg::CLS_HIST_PTR, 1'b0, 1'b0, 12'h010, 8'h00, 3'h4},
        '{pawt_pkg::CLS_LOG_PTR, 1'b0, 1'b1, 12'h028, 8'h11, 3'h4},
        '{pawt_pkg::CLS_MSG_DATA, 1'b1, 1'b0, 12'h010, 8'h00, 3'h5},
        '{pawt_pkg::CLS_MSG_DATA, 1'b1, 1'b1, 12'h01c, 8'h01, 3'h3},
        '{pawt_pkg::CLS_MSG_DATA, 1'b0, 1'b1, 12'h030, 8'h01, 3'h4},
        '{pawt_pkg::CLS_MSG_OTHER, 1'b0, 1'b0, 12'h010, 8'h11, 3'h4},
        '{pawt_pkg::CLS_NONE, 1'b0, 1'b0, 12'h010, 8'h00, 3'h0},
        '{pawt_pkg::CLS_LOG_PTR, 1'b1, 1'b0, 12'h010, 8'h00, 3'h0},
        '{pawt_pkg::CLS_MSG_OTHER, 1'b1, 1'b1, 12'h010, 8'h00, 3'h0}};

    always #2 i_clk = ~i_clk;

    pawt_timer i_pawt_timer (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_acc_req(acc_req), .i_acc_wr(acc_wr),
        .i_acc_size16(acc_s16), .i_acc_cls(acc_cls), .i_system_wait_control(swc), .i_clk_ratio(ratio),
        .i_cpu_on_subclk_main_off(sub_off), .i_cpu_on_int_osc(int_osc), .o_stall_ff(stall),
        .o_done_ff(done), .o_locked_ff(locked));
    pawt_core_model i_pawt_core_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go), .i_wr(wr),
        .i_size16(s16), .i_cls(cls), .i_stall(stall), .i_done(done), .o_req_ff(acc_req), .o_wr_ff(acc_wr),
        .o_size16_ff(acc_s16), .o_cls_ff(acc_cls), .o_fin_ff(fin), .o_cnt_ff(cnt));

    // whole stall length, with the fractional wait factor rounded up
    function automatic logic [15:0] exp_n(input pawt_row_t r);
        int d;
        int k;
        d = (2 + int'(r.swc[0])) * 16;
        k = (int'(r.m) * int'(r.ratio) + 16 + d - 1) / d;
        if (r.m == 3'h0) return 16'h0000;
        return 16'(3 + int'(r.swc[4]) + int'(r.swc[0]) + (2 + int'(r.swc[0])) * k);
    endfunction

    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic start(input pawt_row_t r);
        @(posedge i_clk);
        go <= 1'b1;
        wr <= r.wr;
        s16 <= r.s16;
        cls <= r.cls;
        ratio <= r.ratio;
        swc <= r.swc;
    endtask

    task automatic wait_fin();
        int t;
        for (t = 0; t < 300; t++) begin
            @(posedge i_clk);
            #1;
            if (fin) break;
        end
        if (t == 300) begin
            check(16'h0000, 16'h0001);
            wrap_up();
        end
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1;
        check({13'h0000, stall, done, locked}, 16'h0000);
        foreach (rows[n]) begin
            start(rows[n]);
            @(posedge i_clk);
            go <= 1'b0;
            wait_fin();
            check(cnt, exp_n(rows[n]));
        end
        // go held high: the second access follows straight after the first
        start(rows[5]);
        wait_fin();
        check(cnt, exp_n(rows[5]));
        @(posedge i_clk);
        go <= 1'b0;
        wait_fin();
        check(cnt, exp_n(rows[5]));
        // forbidden clock on purpose: the wait may only end by reset
        for (int f = 0; f < 2; f++) begin
            @(posedge i_clk);
            sub_off <= (f == 0);
            int_osc <= (f == 1);
            start(rows[0]);
            @(posedge i_clk);
            go <= 1'b0;
            repeat (60) @(posedge i_clk);
            #1;
            check({13'h0000, stall, done, locked}, 16'h0005);
            @(posedge i_clk);
            i_rst_b <= 1'b0;
            sub_off <= 1'b0;
            int_osc <= 1'b0;
            repeat (2) @(posedge i_clk);
            i_rst_b <= 1'b1;
            #1;
            check({13'h0000, stall, done, locked}, 16'h0000);
        end
        start(rows[1]);
        @(posedge i_clk);
        go <= 1'b0;
        wait_fin();
        check(cnt, exp_n(rows[1]));
        wrap_up();
    end
endmodule
`default_nettype wire
